// ==== inc/irf_pkg.sv ====
// package: register map, field positions and reset values of the request flags
//
// Behaviour
// - set direct transition flag, bit 7, on sleep transition while transition-on is 1
// - direct transition flag clears only when software writes 0 there
// - set interval timer flag, bit 6, on every interval timer overflow
// - interval timer flag clears only when software writes 0 there
// - flag register bits 5,4 and wakeup register bits 7,6 read as 1
// - external request pin in interrupt mode with selected edge sets its flag
// - each external request flag clears only by writing 0 to its bit
// - wakeup pin in interrupt mode with selected edge sets its wakeup flag
// - each wakeup flag clears only by writing 0 to its bit
// - external request edge select: 0 falling edge, 1 rising edge
// - wakeup edge select: 0 falling edge, 1 rising edge
// - one shared wakeup enable bit forwards requests of all six wakeup flags
package irf_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int EXT_COUNT  = 4;
   localparam int WAKE_COUNT = 6;
   localparam int ADDR_W     = 4;
   localparam int DATA_W     = 8;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [3:0] ADDR_IRQ_FLAGS  = 4'h0;
   localparam logic [3:0] ADDR_WAKE_FLAGS = 4'h1;
   localparam logic [3:0] ADDR_ENABLE     = 4'h2;
   localparam logic [3:0] ADDR_STATUS     = 4'h3;
   localparam logic [3:0] ADDR_CLEAR      = 4'h4;

   // ----------------------------------------
   // field positions (flag, enable and status share DT and TA; WAKE is in enable and status only)
   // ----------------------------------------
   localparam int DT_BIT   = 7;
   localparam int TA_BIT   = 6;
   localparam int WAKE_BIT = 5;

   // ----------------------------------------
   // reserved bits and reset values
   // ----------------------------------------
   localparam logic [7:0] IRQ_RSVD_MASK  = 8'h30;
   localparam logic [7:0] WAKE_RSVD_MASK = 8'hC0;
   localparam logic [7:0] EN_RSVD_MASK   = 8'h10;
   localparam logic [7:0] EN_WRITE_MASK  = 8'hEF;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [2:0] PRIME_RESET    = 3'h0;

endpackage

// ==== verilog/irf_edge_detect.sv ====
// module: pin synchroniser and selectable edge detector for a group of request pins
`timescale 1ns/1ns
`default_nettype none
module irf_edge_detect
   import irf_pkg::*;
#(
   parameter int WIDTH = 4
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // pins and configuration
   input  wire logic [WIDTH-1:0] pin_in,
   input  wire logic [WIDTH-1:0] edge_sel,
   input  wire logic [WIDTH-1:0] pin_mode,
   // detected edges, one cycle each
   output logic      [WIDTH-1:0] edge_pulse
);

   logic [WIDTH-1:0] sync_a;
   logic [WIDTH-1:0] sync_b;
   logic [WIDTH-1:0] prev;
   logic [2:0]       prime;
   logic [2:0]       next_prime;

   // ----------------------------------------
   // synchroniser and history
   // ----------------------------------------
   // no edge until the history holds a real sample, so a pin
   // resting high after reset raises no false rising edge
   always_comb
   begin
      next_prime = {prime[1:0], 1'b1};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync_a <= '0;
         sync_b <= '0;
         prev   <= '0;
         prime  <= PRIME_RESET;
      end
      else
      begin
         sync_a <= pin_in;
         sync_b <= sync_a;
         prev   <= sync_b;
         prime  <= next_prime;
      end
   end

   // ----------------------------------------
   // edge choice per pin
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_pin
         // edge select 1 picks rising, 0 falling
         assign edge_pulse[i] = prime[2] && pin_mode[i] &&
            (edge_sel[i] ? (sync_b[i] && !prev[i]) : (!sync_b[i] && prev[i]));

         sel_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
            prime[2] && pin_mode[i] && edge_sel[i] && sync_b[i] && !prev[i] |-> edge_pulse[i])
            else $error("selected rising edge missed");
         fall_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
            edge_pulse[i] && !edge_sel[i] |-> !sync_b[i] && prev[i])
            else $error("falling edge pulse without falling input");
      end
   endgenerate

endmodule
`default_nettype wire

// ==== verilog/irf_flag_bank.sv ====
// module: bank of sticky request flags, set by hardware, cleared by writing 0
`timescale 1ns/1ns
`default_nettype none
module irf_flag_bank
   import irf_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // hardware events
   input  wire logic [WIDTH-1:0] set_pulse,
   // software write
   input  wire logic             wr_hit,
   input  wire logic [WIDTH-1:0] wr_data,
   // flags
   output logic      [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] next_flags;
   logic [WIDTH-1:0] clr_mask;

   // ----------------------------------------
   // set beats clear
   // ----------------------------------------
   always_comb
   begin
      // only bits written 0 clear; a 1 leaves the flag alone
      clr_mask   = wr_hit ? ~wr_data : '0;
      next_flags = (flags & ~clr_mask) | set_pulse;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         flags <= '0;
      else
         flags <= next_flags;
   end

   one_keeps_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_hit |=> (flags & $past(flags) & $past(wr_data)) == ($past(flags) & $past(wr_data)))
      else $error("writing 1 changed a flag");
   set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
      |set_pulse |=> (flags & $past(set_pulse)) == $past(set_pulse))
      else $error("set event lost");

endmodule
`default_nettype wire

// ==== verilog/irf_top.sv ====
// module: interrupt request flag registers with register port and interrupt output
`timescale 1ns/1ns
`default_nettype none
module irf_top
   import irf_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // register port
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wr_data,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_W-1:0]     reg_rd_data,
   // internal event sources, same clock
   input  wire logic                  sleep_direct_transition,
   input  wire logic                  direct_transition_on,
   input  wire logic                  timer_overflow,
   // external request pins and their configuration
   input  wire logic [EXT_COUNT-1:0]  ext_req_pin,
   input  wire logic [EXT_COUNT-1:0]  ext_req_edge_select,
   input  wire logic [EXT_COUNT-1:0]  ext_req_pin_mode,
   // wakeup pins and their configuration
   input  wire logic [WAKE_COUNT-1:0] wake_pin,
   input  wire logic [WAKE_COUNT-1:0] wake_edge_select,
   input  wire logic [WAKE_COUNT-1:0] wake_pin_mode,
   // requests
   output logic                       wake_request,
   output logic                       irq
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [EXT_COUNT-1:0]  ext_pulse;
   logic [WAKE_COUNT-1:0] wake_pulse;
   logic [7:0]            irq_set;
   logic [7:0]            irq_flags;
   logic [WAKE_COUNT-1:0] wake_flags;
   logic                  wr_irq;
   logic                  wr_wake;
   logic                  wr_en;
   logic                  wr_clr;
   logic                  dt_event;
   logic [7:0]            event_set;
   logic [7:0]            irq_enable;
   logic [7:0]            next_irq_enable;
   logic [7:0]            event_status;
   logic [7:0]            next_event_status;
   logic [7:0]            next_rd_data;
   logic                  next_irq;
   logic                  next_wake_request;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] target);
      hit = (a == target);
   endfunction

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   assign wr_irq  = reg_wr && hit(reg_addr, ADDR_IRQ_FLAGS);
   assign wr_wake = reg_wr && hit(reg_addr, ADDR_WAKE_FLAGS);
   assign wr_en   = reg_wr && hit(reg_addr, ADDR_ENABLE);
   assign wr_clr  = reg_wr && hit(reg_addr, ADDR_CLEAR);

   // ----------------------------------------
   // edge detection on the pins
   // ----------------------------------------
   irf_edge_detect #(
      .WIDTH      (EXT_COUNT)
   ) u_ext_edge (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .pin_in     (ext_req_pin),
      .edge_sel   (ext_req_edge_select),
      .pin_mode   (ext_req_pin_mode),
      .edge_pulse (ext_pulse)
   );

   irf_edge_detect #(
      .WIDTH      (WAKE_COUNT)
   ) u_wake_edge (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .pin_in     (wake_pin),
      .edge_sel   (wake_edge_select),
      .pin_mode   (wake_pin_mode),
      .edge_pulse (wake_pulse)
   );

   // ----------------------------------------
   // request flag registers
   // ----------------------------------------
   // a sleep transition counts only while transition-on is set
   assign dt_event = sleep_direct_transition && direct_transition_on;

   always_comb
   begin
      irq_set                     = '0;
      irq_set[DT_BIT]             = dt_event;
      irq_set[TA_BIT]             = timer_overflow;
      irq_set[EXT_COUNT-1:0]      = ext_pulse;
   end

   irf_flag_bank #(
      .WIDTH      (8)
   ) u_irq_bank (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .set_pulse  (irq_set),
      .wr_hit     (wr_irq),
      .wr_data    (reg_wr_data & ~IRQ_RSVD_MASK),
      .flags      (irq_flags)
   );

   irf_flag_bank #(
      .WIDTH      (WAKE_COUNT)
   ) u_wake_bank (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .set_pulse  (wake_pulse),
      .wr_hit     (wr_wake),
      .wr_data    (reg_wr_data[WAKE_COUNT-1:0]),
      .flags      (wake_flags)
   );

   // ----------------------------------------
   // enable, sticky status and clear
   // ----------------------------------------
   always_comb
   begin
      event_set                 = irq_set & ~IRQ_RSVD_MASK;
      event_set[WAKE_BIT]       = |wake_pulse;
      next_irq_enable           = wr_en ? (reg_wr_data & EN_WRITE_MASK) : irq_enable;
      // an event in the clearing cycle survives the clear
      next_event_status         = (event_status & ~(wr_clr ? reg_wr_data : 8'h00))
                                  | event_set;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irq_enable   <= REG_RESET;
         event_status <= REG_RESET;
      end
      else
      begin
         irq_enable   <= next_irq_enable;
         event_status <= next_event_status;
      end
   end

   // ----------------------------------------
   // request outputs
   // ----------------------------------------
   always_comb
   begin
      // one enable bit forwards the whole wakeup group
      next_wake_request = (|wake_flags) && irq_enable[WAKE_BIT];
      next_irq          = |(event_status & irq_enable);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wake_request <= 1'b0;
         irq          <= 1'b0;
      end
      else
      begin
         wake_request <= next_wake_request;
         irq          <= next_irq;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   // data stand one cycle after the strobe only; unmapped reads give zero
   always_comb
   begin
      next_rd_data = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_IRQ_FLAGS:  next_rd_data = irq_flags | IRQ_RSVD_MASK;
            ADDR_WAKE_FLAGS: next_rd_data = {2'b00, wake_flags} | WAKE_RSVD_MASK;
            ADDR_ENABLE:     next_rd_data = irq_enable | EN_RSVD_MASK;
            ADDR_STATUS:     next_rd_data = event_status;
            default:         next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rd_data <= 8'h00;
      else
         reg_rd_data <= next_rd_data;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   dt_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      sleep_direct_transition && direct_transition_on |=> irq_flags[DT_BIT])
      else $error("direct transition flag not set");

   dt_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      !irq_flags[DT_BIT] && !(sleep_direct_transition && direct_transition_on)
      |=> !irq_flags[DT_BIT])
      else $error("direct transition flag set without cause");

   dt_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      irq_flags[DT_BIT] && !(wr_irq && !reg_wr_data[DT_BIT]) |=> irq_flags[DT_BIT])
      else $error("direct transition flag lost");

   ta_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      timer_overflow |=> irq_flags[TA_BIT])
      else $error("interval timer flag not set");

   ta_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_irq && !reg_wr_data[TA_BIT] && !timer_overflow |=> !irq_flags[TA_BIT])
      else $error("interval timer flag not cleared by 0");

   rsvd_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_IRQ_FLAGS |=> reg_rd_data[5:4] == 2'b11)
      else $error("reserved flag bits not read as 1");

   wake_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_WAKE_FLAGS |=> reg_rd_data[7:6] == 2'b11)
      else $error("reserved wakeup bits not read as 1");

   ext_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      |ext_pulse |=> (irq_flags[EXT_COUNT-1:0] & $past(ext_pulse)) == $past(ext_pulse))
      else $error("external request flag not set");

   ext_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_irq && reg_wr_data[3:0] == 4'hE && ext_pulse == 4'h0
      |=> !irq_flags[0] && irq_flags[3:1] == $past(irq_flags[3:1]))
      else $error("external flag clear touched another bit");

   wake_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      |wake_pulse |=> (wake_flags & $past(wake_pulse)) == $past(wake_pulse))
      else $error("wakeup flag not set");

   wake_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      !wr_wake && wake_pulse == 6'h00 |=> wake_flags == $past(wake_flags))
      else $error("wakeup flag changed without cause");

   wake_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 wake_request == ((|$past(wake_flags)) && $past(irq_enable[WAKE_BIT])))
      else $error("wakeup request not gated by group enable");

   irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
      (|(event_status & irq_enable)) |=> irq)
      else $error("interrupt output missed an enabled status bit");

   rd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rd_data == 8'h00)
      else $error("read data outside the answer cycle");

   dt_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_irq && !reg_wr_data[DT_BIT] && !dt_event |=> !irq_flags[DT_BIT])
      else $error("direct transition flag not cleared by 0");

   ta_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      irq_flags[TA_BIT] && !(wr_irq && !reg_wr_data[TA_BIT]) |=> irq_flags[TA_BIT])
      else $error("interval timer flag lost");

   ext_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !wr_irq |=> (irq_flags[EXT_COUNT-1:0] | ~$past(irq_flags[EXT_COUNT-1:0])) == 4'hF)
      else $error("external flag cleared without a write");

   wake_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_wake && wake_pulse == 6'h00
      |=> wake_flags == ($past(wake_flags) & $past(reg_wr_data[WAKE_COUNT-1:0])))
      else $error("wakeup flag write not applied bit by bit");

   en_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en |=> irq_enable == ($past(reg_wr_data) & EN_WRITE_MASK))
      else $error("enable write not taken");

   en_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !wr_en |=> $stable(irq_enable))
      else $error("enable changed without a write");

   en_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_ENABLE |=> reg_rd_data[4])
      else $error("reserved enable bit not read as 1");

   status_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      |event_set |=> (event_status & $past(event_set)) == $past(event_set))
      else $error("status event lost");

   status_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_clr && event_set == 8'h00
      |=> event_status == ($past(event_status) & ~$past(reg_wr_data)))
      else $error("status clear not applied");

   irq_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      !(|(event_status & irq_enable)) |=> !irq)
      else $error("interrupt output high without an enabled status bit");

   status_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_STATUS |=> reg_rd_data == $past(event_status))
      else $error("status read does not match the register");

endmodule
`default_nettype wire

// ==== dv/irf_source_model.sv ====
// partner model: internal event sources and request pins feeding the flag block
`timescale 1ns/1ns
`default_nettype none
module irf_source_model
   import irf_pkg::*;
(
   // clock
   input  wire logic                  clk,
   // event sources
   output logic                       sleep_direct_transition,
   output logic                       direct_transition_on,
   output logic                       timer_overflow,
   // request pins
   output logic      [EXT_COUNT-1:0]  ext_req_pin,
   output logic      [WAKE_COUNT-1:0] wake_pin
);
   // ----------------------------------------
   // idle levels: pins rest opposite to their selected edge
   // ----------------------------------------
   initial
   begin
      sleep_direct_transition = 1'b0;
      direct_transition_on    = 1'b0;
      timer_overflow          = 1'b0;
      ext_req_pin             = 4'hA;
      wake_pin                = 6'h2A;
   end

   // ----------------------------------------
   // event pulses, one clock wide
   // ----------------------------------------
   task automatic pulse_sleep(input logic on);
      @(posedge clk);
      direct_transition_on    <= on;
      sleep_direct_transition <= 1'b1;
      @(posedge clk);
      sleep_direct_transition <= 1'b0;
   endtask

   task automatic pulse_timer;
      @(posedge clk);
      timer_overflow <= 1'b1;
      @(posedge clk);
      timer_overflow <= 1'b0;
   endtask

   // pins are asynchronous in the field; here they move after an edge
   task automatic drive_pins(input logic [3:0] e, input logic [5:0] w);
      @(posedge clk);
      ext_req_pin <= e;
      wake_pin    <= w;
   endtask
endmodule
`default_nettype wire

// ==== dv/irf_tb_top.sv ====
// testbench: register access, event flags, pin edges and interrupt output
`timescale 1ns/1ns
`default_nettype none
module irf_tb_top
   import irf_pkg::*;
;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic                  clk;
   logic                  sys_rst;
   logic [ADDR_W-1:0]     reg_addr;
   logic [DATA_W-1:0]     reg_wr_data;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [DATA_W-1:0]     reg_rd_data;
   logic                  sdt;
   logic                  dt_on;
   logic                  tovf;
   logic [EXT_COUNT-1:0]  ext_pin;
   logic [WAKE_COUNT-1:0] wk_pin;
   logic [EXT_COUNT-1:0]  ext_sel;
   logic [EXT_COUNT-1:0]  ext_mode;
   logic [WAKE_COUNT-1:0] wk_sel;
   logic [WAKE_COUNT-1:0] wk_mode;
   logic                  wake_request;
   logic                  irq;
   logic [7:0]            rdata;
   int                    fails;
   int                    checks_done;

   // ----------------------------------------
   // instances
   // ----------------------------------------
   irf_source_model irf_source_model_inst (
      .clk(clk), .sleep_direct_transition(sdt), .direct_transition_on(dt_on),
      .timer_overflow(tovf), .ext_req_pin(ext_pin), .wake_pin(wk_pin));

   // edge selects and modes start with pin3 and wake5 out of interrupt mode
   irf_top irf_top_inst (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
      .sleep_direct_transition(sdt), .direct_transition_on(dt_on), .timer_overflow(tovf),
      .ext_req_pin(ext_pin), .ext_req_edge_select(ext_sel), .ext_req_pin_mode(ext_mode),
      .wake_pin(wk_pin), .wake_edge_select(wk_sel), .wake_pin_mode(wk_mode),
      .wake_request(wake_request), .irq(irq));

   // ----------------------------------------
   // clock, common tasks
   // ----------------------------------------
   initial clk = 1'b0;
   always #20 clk = ~clk;

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr      <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rdata = reg_rd_data;
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset_values;
      reg_read(ADDR_IRQ_FLAGS);
      check("irq flags", rdata, 8'h30);
      reg_read(ADDR_WAKE_FLAGS);
      check("wake flags", rdata, 8'hC0);
      reg_read(ADDR_ENABLE);
      check("enable", rdata, 8'h10);
      reg_read(ADDR_STATUS);
      check("status", rdata, 8'h00);
      reg_read(4'h9);
      check("unmapped", rdata, 8'h00);
   endtask

   task automatic test_events;
      irf_source_model_inst.pulse_sleep(1'b0);
      reg_read(ADDR_IRQ_FLAGS);
      check("sleep without on", rdata, 8'h30);
      irf_source_model_inst.pulse_sleep(1'b1);
      irf_source_model_inst.pulse_timer();
      reg_read(ADDR_IRQ_FLAGS);
      check("event flags", rdata, 8'hF0);
      reg_write(ADDR_IRQ_FLAGS, 8'hFF);
      reg_read(ADDR_IRQ_FLAGS);
      check("write ones", rdata, 8'hF0);
      reg_write(ADDR_IRQ_FLAGS, 8'hBF);
      reg_read(ADDR_IRQ_FLAGS);
      check("timer flag cleared", rdata, 8'hB0);
      reg_write(ADDR_IRQ_FLAGS, 8'h7F);
      reg_read(ADDR_IRQ_FLAGS);
      check("dt flag cleared", rdata, 8'h30);
   endtask

   // each pin moves to its selected edge, then back over the opposite one
   task automatic test_pins;
      irf_source_model_inst.drive_pins(4'h5, 6'h15);
      tick(8);
      reg_read(ADDR_IRQ_FLAGS);
      check("ext edges", rdata, 8'h37);
      reg_read(ADDR_WAKE_FLAGS);
      check("wake edges", rdata, 8'hDF);
      reg_write(ADDR_IRQ_FLAGS, 8'hFE);
      reg_read(ADDR_IRQ_FLAGS);
      check("ext0 cleared", rdata, 8'h36);
      reg_write(ADDR_WAKE_FLAGS, 8'hFB);
      reg_read(ADDR_WAKE_FLAGS);
      check("wake2 cleared", rdata, 8'hDB);
      reg_write(ADDR_IRQ_FLAGS, 8'h00);
      reg_write(ADDR_WAKE_FLAGS, 8'h00);
      irf_source_model_inst.drive_pins(4'hA, 6'h2A);
      tick(8);
      reg_read(ADDR_IRQ_FLAGS);
      check("ext opposite edge", rdata, 8'h30);
      reg_read(ADDR_WAKE_FLAGS);
      check("wake opposite edge", rdata, 8'hC0);
      // inverted selects, every pin open: the old edges miss, the return edges hit
      @(posedge clk);
      ext_sel  <= 4'hA;
      ext_mode <= 4'hF;
      wk_sel   <= 6'h2A;
      wk_mode  <= 6'h3F;
      irf_source_model_inst.drive_pins(4'h5, 6'h15);
      tick(8);
      reg_read(ADDR_IRQ_FLAGS);
      check("ext wrong edge", rdata, 8'h30);
      reg_read(ADDR_WAKE_FLAGS);
      check("wake wrong edge", rdata, 8'hC0);
      irf_source_model_inst.drive_pins(4'hA, 6'h2A);
      tick(8);
      reg_read(ADDR_IRQ_FLAGS);
      check("ext all pins", rdata, 8'h3F);
      reg_read(ADDR_WAKE_FLAGS);
      check("wake all pins", rdata, 8'hFF);
      reg_write(ADDR_IRQ_FLAGS, 8'h00);
      reg_write(ADDR_WAKE_FLAGS, 8'h00);
      ext_sel <= 4'h5;
      wk_sel  <= 6'h15;
   endtask

   task automatic test_wake_enable;
      reg_write(ADDR_ENABLE, 8'h20);
      reg_read(ADDR_ENABLE);
      check("enable readback", rdata, 8'h30);
      irf_source_model_inst.drive_pins(4'hA, 6'h2B);
      tick(8);
      @(negedge clk);
      check("wake request on", {7'h00, wake_request}, 8'h01);
      reg_write(ADDR_ENABLE, 8'h00);
      tick(2);
      @(negedge clk);
      check("wake request masked", {7'h00, wake_request}, 8'h00);
      irf_source_model_inst.drive_pins(4'hA, 6'h2A);
      reg_write(ADDR_WAKE_FLAGS, 8'h00);
      reg_write(ADDR_CLEAR, 8'hFF);
   endtask

   task automatic test_irq;
      reg_write(ADDR_ENABLE, 8'h40);
      irf_source_model_inst.pulse_timer();
      tick(2);
      @(negedge clk);
      check("irq raised", {7'h00, irq}, 8'h01);
      reg_read(ADDR_STATUS);
      check("status", rdata, 8'h40);
      reg_write(ADDR_CLEAR, 8'h40);
      tick(2);
      @(negedge clk);
      check("irq cleared", {7'h00, irq}, 8'h00);
      reg_write(ADDR_ENABLE, 8'h80);
      irf_source_model_inst.pulse_timer();
      tick(3);
      @(negedge clk);
      check("irq masked", {7'h00, irq}, 8'h00);
      irf_source_model_inst.pulse_sleep(1'b1);
      tick(2);
      @(negedge clk);
      check("irq on dt", {7'h00, irq}, 8'h01);
   endtask

   // a second reset in mid-run must drop every irq flag, status bit and the irq output
   task automatic test_mid_reset;
      @(posedge clk);
      sys_rst <= 1'b1;
      tick(3);
      sys_rst <= 1'b0;
      tick(4);
      @(negedge clk);
      check("irq after reset", {7'h00, irq}, 8'h00);
      reg_read(ADDR_IRQ_FLAGS);
      check("flags after reset", rdata, 8'h30);
      reg_read(ADDR_STATUS);
      check("status after reset", rdata, 8'h00);
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      fails       = 0;
      checks_done = 0;
      sys_rst     = 1'b1;
      reg_addr    = 4'h0;
      reg_wr_data = 8'h00;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      ext_sel     = 4'h5;
      ext_mode    = 4'h7;
      wk_sel      = 6'h15;
      wk_mode     = 6'h1F;
      tick(3);
      sys_rst <= 1'b0;
      // edge history needs a few cycles to fill after reset
      tick(4);
      test_reset_values();
      test_events();
      test_pins();
      test_wake_enable();
      test_irq();
      test_mid_reset();
      print_verdict();
   end

   // whole run is under two hundred cycles; allow ample margin
   initial
   begin
      #(40 * 5000);
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
